// *** design/scrl_top.sv ***
// Speed command conditioning: up/down command, ramp, low-pass filter, forward limit.
// Assumes an APB master on pclk, analog inputs sampled on pclk, digital inputs from pins.
`timescale 1ns/1ps
`include "scrl_consts.svh"

module scrl_top
  import scrl_pkg::*;
#(
  parameter int TICK_CYCLES = `SCRL_TICK_CYCLES,
  parameter int RATED_RPM   = `SCRL_RATED_RPM
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               speed_up_input,
  input  wire logic               speed_down_input,
  input  wire logic               forward_limit_b_switch,
  input  wire logic signed [15:0] speed_source,
  input  wire logic signed [15:0] analog_input_one,
  input  wire logic signed [15:0] analog_input_two,
  output logic signed [15:0]      speed_command
);

  logic [15:0]          filt_tc_reg;
  logic [15:0]          acc_time_reg;
  logic [15:0]          dec_time_reg;
  scrl_fwd_sel_t        fwd_sel_reg;
  scrl_src_t            a_src_reg;
  scrl_src_t            b_src_reg;
  logic [14:0]          a_val_reg;
  logic [14:0]          b_val_reg;
  logic                 updown_mode_reg;
  logic [14:0]          step_reg;
  logic [31:0]          rdata_reg;
  logic signed [15:0]   updown_reg;
  logic signed [15:0]   ramp_reg;
  logic [32:0]          ramp_acc_reg;
  logic signed [23:0]   filt_reg;
  logic [31:0]          tick_cnt_reg;
  logic                 tick;
  logic [2:0]           pin_raw;
  logic [2:0]           pin_ff1_reg;
  logic [2:0]           pin_ff2_reg;
  logic [2:0]           pin_ff3_reg;
  logic [2:0]           pin_reg;
  logic                 up_act;
  logic                 down_act;
  logic                 sw_act;
  logic                 wr_en;
  logic                 rd_setup;
  logic                 mapped;
  logic signed [15:0]   src_sel;
  logic [14:0]          lim_a;
  logic [14:0]          lim_b;
  logic [14:0]          lim;
  logic signed [15:0]   target;
  logic [15:0]          ramp_time;
  logic [32:0]          ramp_thresh;
  logic [32:0]          ramp_sum;
  logic signed [24:0]   filt_err;
  logic signed [24:0]   filt_delta;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = rdata_reg;

  // Address decode; word aligned only, so low bits set is unmapped
  always_comb begin
    case (paddr)
      `SCRL_OFS_FILT_TC, `SCRL_OFS_ACC_TIME, `SCRL_OFS_DEC_TIME, `SCRL_OFS_FWD_SEL,
      `SCRL_OFS_A_SRC, `SCRL_OFS_A_VAL, `SCRL_OFS_B_SRC, `SCRL_OFS_B_VAL,
      `SCRL_OFS_CTRL, `SCRL_OFS_STEP, `SCRL_OFS_ST_FINAL, `SCRL_OFS_ST_RAMP,
      `SCRL_OFS_ST_TARGET: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // Register writes take effect at the access edge, no shadowing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_tc_reg     <= `SCRL_RST_FILT_TC;
      acc_time_reg    <= `SCRL_RST_ACC_TIME;
      dec_time_reg    <= `SCRL_RST_DEC_TIME;
      fwd_sel_reg     <= SCRL_LIM_A;
      a_src_reg       <= SCRL_SRC_DIGITAL;
      b_src_reg       <= SCRL_SRC_DIGITAL;
      a_val_reg       <= `SCRL_RST_LIM_VAL;
      b_val_reg       <= `SCRL_RST_LIM_VAL;
      updown_mode_reg <= 1'b0;
      step_reg        <= `SCRL_RST_STEP;
    end else if (wr_en) begin
      case (paddr)
        `SCRL_OFS_FILT_TC:  filt_tc_reg  <= {1'b0, pwdata[14:0]};
        `SCRL_OFS_ACC_TIME: acc_time_reg <= pwdata[15:0];
        `SCRL_OFS_DEC_TIME: dec_time_reg <= pwdata[15:0];
        `SCRL_OFS_FWD_SEL:  fwd_sel_reg  <= scrl_fwd_sel_t'(pwdata[1:0]);
        `SCRL_OFS_A_SRC:    a_src_reg    <= scrl_src_t'(pwdata[1:0]);
        `SCRL_OFS_A_VAL:    a_val_reg    <= pwdata[14:0];
        `SCRL_OFS_B_SRC:    b_src_reg    <= scrl_src_t'(pwdata[1:0]);
        `SCRL_OFS_B_VAL:    b_val_reg    <= pwdata[14:0];
        `SCRL_OFS_CTRL:     updown_mode_reg <= pwdata[0];
        `SCRL_OFS_STEP:     step_reg     <= pwdata[14:0];
        default:            step_reg     <= step_reg; // Status words are read only
      endcase
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `SCRL_OFS_FILT_TC:   rdata_reg <= {16'h0000, filt_tc_reg};
        `SCRL_OFS_ACC_TIME:  rdata_reg <= {16'h0000, acc_time_reg};
        `SCRL_OFS_DEC_TIME:  rdata_reg <= {16'h0000, dec_time_reg};
        `SCRL_OFS_FWD_SEL:   rdata_reg <= {30'h00000000, fwd_sel_reg};
        `SCRL_OFS_A_SRC:     rdata_reg <= {30'h00000000, a_src_reg};
        `SCRL_OFS_A_VAL:     rdata_reg <= {17'h00000, a_val_reg};
        `SCRL_OFS_B_SRC:     rdata_reg <= {30'h00000000, b_src_reg};
        `SCRL_OFS_B_VAL:     rdata_reg <= {17'h00000, b_val_reg};
        `SCRL_OFS_CTRL:      rdata_reg <= {31'h00000000, updown_mode_reg};
        `SCRL_OFS_STEP:      rdata_reg <= {17'h00000, step_reg};
        `SCRL_OFS_ST_FINAL:  rdata_reg <= {{16{speed_command[15]}}, speed_command};
        `SCRL_OFS_ST_RAMP:   rdata_reg <= {{16{ramp_reg[15]}}, ramp_reg};
        `SCRL_OFS_ST_TARGET: rdata_reg <= {{16{target[15]}}, target};
        default:             rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Pin inputs: three flops, a change counts once the second and third agree
  assign pin_raw = {forward_limit_b_switch, speed_down_input, speed_up_input};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_ff1_reg[gi] <= 1'b0;
          pin_ff2_reg[gi] <= 1'b0;
          pin_ff3_reg[gi] <= 1'b0;
          pin_reg[gi]     <= 1'b0;
        end else begin
          pin_ff1_reg[gi] <= pin_raw[gi];
          pin_ff2_reg[gi] <= pin_ff1_reg[gi];
          pin_ff3_reg[gi] <= pin_ff2_reg[gi];
          if (pin_ff2_reg[gi] == pin_ff3_reg[gi]) begin
            pin_reg[gi] <= pin_ff3_reg[gi];
          end
        end
      end
    end
  endgenerate
  assign up_act   = pin_reg[0];
  assign down_act = pin_reg[1];
  assign sw_act   = pin_reg[2];

  // Millisecond tick paces the up/down command and the filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // Up/down command moves one step per tick, saturating at full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      updown_reg <= 16'sh0000;
    end else if (tick && updown_mode_reg) begin
      if (up_act && !down_act) begin
        if (updown_reg > `SCRL_MAX_SPEED - $signed({1'b0, step_reg})) begin
          updown_reg <= `SCRL_MAX_SPEED;
        end else begin
          updown_reg <= updown_reg + $signed({1'b0, step_reg});
        end
      end else if (down_act && !up_act) begin
        if (updown_reg < -`SCRL_MAX_SPEED + $signed({1'b0, step_reg})) begin
          updown_reg <= -`SCRL_MAX_SPEED;
        end else begin
          updown_reg <= updown_reg - $signed({1'b0, step_reg});
        end
      end
      // Neither or both inputs: no assignment, command holds
    end
  end

  // Limiter sources; a negative analog level counts as zero limit
  function automatic logic [14:0] lim_pick(scrl_src_t s, logic [14:0] dig,
                                            logic signed [15:0] a1,
                                            logic signed [15:0] a2);
    logic [14:0] r;
    r = dig;
    case (s)
      SCRL_SRC_ANALOG_ONE: r = a1[15] ? 15'h0000 : a1[14:0];
      SCRL_SRC_ANALOG_TWO: r = a2[15] ? 15'h0000 : a2[14:0];
      default:             r = dig; // Third analog input absent: digital value
    endcase
    return r;
  endfunction

  assign lim_a = lim_pick(a_src_reg, a_val_reg, analog_input_one, analog_input_two);
  assign lim_b = lim_pick(b_src_reg, b_val_reg, analog_input_one, analog_input_two);

  // Forward limit choice; reverse direction passes unlimited here
  always_comb begin
    case (fwd_sel_reg)
      SCRL_LIM_A:      lim = lim_a;
      SCRL_LIM_B:      lim = lim_b;
      SCRL_LIM_SWITCH: lim = sw_act ? lim_b : lim_a;
      SCRL_LIM_BOTH:   lim = (lim_a < lim_b) ? lim_a : lim_b;
      default:         lim = lim_a;
    endcase
    src_sel = updown_mode_reg ? updown_reg : speed_source;
    if (src_sel > $signed({1'b0, lim})) begin
      target = $signed({1'b0, lim});
    end else begin
      target = src_sel;
    end
  end

  // Moving away from zero uses acceleration time, toward zero deceleration.
  // Direction is judged from the present ramp value, so a fall from a
  // positive speed to zero decelerates even though the target sits at zero.
  always_comb begin
    if ((target > ramp_reg && ramp_reg >= 16'sh0000) ||
        (target < ramp_reg && ramp_reg <= 16'sh0000)) begin
      ramp_time = acc_time_reg;
    end else begin
      ramp_time = dec_time_reg;
    end
    ramp_thresh = 33'(ramp_time) * 33'(TICK_CYCLES);
    ramp_sum    = ramp_acc_reg + 33'(RATED_RPM);
  end

  // Constant slope of rated speed per ramp time, one rpm per threshold crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_reg     <= 16'sh0000;
      ramp_acc_reg <= 33'h000000000;
    end else if (ramp_reg == target) begin
      ramp_acc_reg <= 33'h000000000;
    end else if (ramp_time == 16'h0000) begin
      ramp_reg     <= target;
      ramp_acc_reg <= 33'h000000000;
    end else if (ramp_sum >= ramp_thresh) begin
      ramp_reg     <= (target > ramp_reg) ? ramp_reg + 16'sh0001 : ramp_reg - 16'sh0001;
      ramp_acc_reg <= ramp_sum - ramp_thresh;
    end else begin
      ramp_acc_reg <= ramp_sum;
    end
  end

  // First-order low-pass in 16.8 fixed point, one update per millisecond
  assign filt_err   = $signed({ramp_reg[15], ramp_reg, 8'h00}) - $signed({filt_reg[23], filt_reg});
  assign filt_delta = filt_err / $signed({9'h000, filt_tc_reg} + 25'h0000001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg <= 24'sh000000;
    end else if (tick) begin
      filt_reg <= filt_reg + filt_delta[23:0];
    end
  end
  assign speed_command = filt_reg[23:8];

  // Assertions on the up/down command, ramp, filter and limits
  sequence s_tick_up;
    tick && updown_mode_reg && up_act && !down_act;
  endsequence
  sequence s_tick_down;
    tick && updown_mode_reg && down_act && !up_act;
  endsequence

  a_updown_raise: assert property (@(posedge pclk) disable iff (!presetn)
    s_tick_up ##0 (updown_reg < 16'sh0100) |=> (updown_reg > $past(updown_reg)))
    else $error("Up input did not raise the command");
  a_updown_lower: assert property (@(posedge pclk) disable iff (!presetn)
    s_tick_down ##0 (updown_reg > -16'sh0100) |=> (updown_reg < $past(updown_reg)))
    else $error("Down input did not lower the command");
  a_updown_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (up_act == down_act) |=> $stable(updown_reg))
    else $error("Command moved with no single input active");
  a_ramp_slope: assert property (@(posedge pclk) disable iff (!presetn)
    (ramp_time != 16'h0000 && ramp_reg != target && $stable(target)) |=>
      (ramp_reg - $past(ramp_reg) <= 16'sh0001 && $past(ramp_reg) - ramp_reg <= 16'sh0001))
    else $error("Ramp stepped by more than one rpm");
  a_ramp_jump: assert property (@(posedge pclk) disable iff (!presetn)
    (ramp_time == 16'h0000) |=> (ramp_reg == $past(target)))
    else $error("Zero ramp time did not pass the target");
  a_filter_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && filt_tc_reg == 16'h0000) |=> (speed_command == $past(ramp_reg)))
    else $error("Zero time constant filter did not pass the ramp");
  a_filter_tick: assert property (@(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(filt_reg))
    else $error("Filter moved between ticks");
  a_limit_both: assert property (@(posedge pclk) disable iff (!presetn)
    (fwd_sel_reg == SCRL_LIM_BOTH) |-> (target <= $signed({1'b0, lim_a})
      && target <= $signed({1'b0, lim_b})))
    else $error("Target above the smaller limit");
  a_limit_switch: assert property (@(posedge pclk) disable iff (!presetn)
    (fwd_sel_reg == SCRL_LIM_SWITCH) |-> (lim == (sw_act ? lim_b : lim_a)))
    else $error("Switch input chose the wrong limiter");
  a_filter_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `SCRL_OFS_FILT_TC) |=> (filt_tc_reg == {1'b0, $past(pwdata[14:0])}))
    else $error("Filter time constant write lost");

  // Ramp time choice: acceleration away from zero, deceleration toward it
  a_accel_select: assert property (@(posedge pclk) disable iff (!presetn)
    (target > ramp_reg && ramp_reg >= 16'sh0000) |-> (ramp_time == acc_time_reg))
    else $error("Acceleration time not used away from zero");
  a_decel_select: assert property (@(posedge pclk) disable iff (!presetn)
    (target < ramp_reg && ramp_reg > 16'sh0000) |-> (ramp_time == dec_time_reg))
    else $error("Deceleration time not used toward zero");
  // Pin filter: a level passes only once the last two flops agree
  a_pin_agree: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_ff2_reg[0] == pin_ff3_reg[0]) |=> (up_act == $past(pin_ff3_reg[0])))
    else $error("Up pin level not taken after the flops agreed");
  a_pin_settle: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_ff2_reg[1] != pin_ff3_reg[1]) |=> $stable(down_act))
    else $error("Down pin level taken before the flops agreed");
  // Limiter B selection clamps the target to limiter B
  a_limit_single: assert property (@(posedge pclk) disable iff (!presetn)
    (fwd_sel_reg == SCRL_LIM_B) |-> (target <= $signed({1'b0, lim_b})))
    else $error("Target above limiter B");
  // Saturation keeps the up/down command inside full scale
  a_updown_range: assert property (@(posedge pclk) disable iff (!presetn)
    updown_reg != 16'sh8000)
    else $error("Up/down command left full scale");

endmodule // scrl_top

// *** design/scrl_consts.svh ***
// Constants of the speed command ramp and limit block: offsets, resets, timing.
// Assumes a 125 MHz pclk and an APB bus with 32-bit data, one word per register.
// Function
// - Up/down mode with up input active raises the speed command.
// - Up/down mode with down input active lowers the speed command.
// - With neither input active the speed command holds its value.
// - Every speed source passes through the acceleration/deceleration ramp.
// - Ramp output feeds a low-pass filter whose output is the final command.
// - Acceleration time is the time from zero to rated speed.
// - Ramp time scales with speed change over rated speed: constant slope.
// - Larger filter time constant gives smoother output and longer lag.
// - Filter constant 0..32767 ms, default 20, takes effect at once.
// - Forward limiting has main limiter A and auxiliary B, each sourced.
// - Forward select: 0 A, 1 B, 2 switch A/B by input, 3 both.
// - Limiter A source: 0 digital, 1 analog one, 2 analog two, 3 unsupported.
// - Limiter A digital value 0..32767 rpm, default 3000.
// - Limiter B source: 0 digital, 1 analog one, 2 analog two, 3 unsupported.
// - In switch mode a valid switch input applies B, else A.
`ifndef SCRL_CONSTS_SVH
`define SCRL_CONSTS_SVH

`define SCRL_OFS_FILT_TC    8'h00
`define SCRL_OFS_ACC_TIME   8'h04
`define SCRL_OFS_DEC_TIME   8'h08
`define SCRL_OFS_FWD_SEL    8'h0c
`define SCRL_OFS_A_SRC      8'h10
`define SCRL_OFS_A_VAL      8'h14
`define SCRL_OFS_B_SRC      8'h18
`define SCRL_OFS_B_VAL      8'h1c
`define SCRL_OFS_CTRL       8'h20
`define SCRL_OFS_STEP       8'h24
`define SCRL_OFS_ST_FINAL   8'h28
`define SCRL_OFS_ST_RAMP    8'h2c
`define SCRL_OFS_ST_TARGET  8'h30

`define SCRL_RST_FILT_TC    16'h0014
`define SCRL_RST_ACC_TIME   16'h01f4
`define SCRL_RST_DEC_TIME   16'h01f4
`define SCRL_RST_LIM_VAL    15'h0bb8
`define SCRL_RST_STEP       15'h0001
`define SCRL_MAX_SPEED      16'sh7fff

// One millisecond tick: time in ns, cycles derived from the 8 ns period
`define SCRL_TICK_NS        1000000
`define SCRL_CLK_NS         8
`define SCRL_TICK_CYCLES    (`SCRL_TICK_NS / `SCRL_CLK_NS)
`define SCRL_RATED_RPM      3000

`endif

// *** design/scrl_pkg.sv ***
// Types of the speed command ramp and limit block.
// Assumes the constants header is included by each design file that needs it.
package scrl_pkg;

  // Forward limit source select
  typedef enum logic [1:0] {
    SCRL_LIM_A,
    SCRL_LIM_B,
    SCRL_LIM_SWITCH,
    SCRL_LIM_BOTH
  } scrl_fwd_sel_t;

  // Limiter value source select; the third analog input has no hardware
  typedef enum logic [1:0] {
    SCRL_SRC_DIGITAL,
    SCRL_SRC_ANALOG_ONE,
    SCRL_SRC_ANALOG_TWO,
    SCRL_SRC_ANALOG_THREE
  } scrl_src_t;

endpackage

// *** test/scrl_pin_ctrl.sv ***
// Partner model: the outside controller that drives the digital function pins.
// Assumes the bench sets the wanted levels; pins change only just after a rising edge.
`timescale 1ns/1ps

module scrl_pin_ctrl (
  input  wire logic pclk,
  input  wire logic want_up,
  input  wire logic want_down,
  input  wire logic want_b,
  output logic      speed_up_input,
  output logic      speed_down_input,
  output logic      forward_limit_b_switch
);
  // Pins idle low from time zero so the synchronisers never see an unknown
  initial begin
    speed_up_input         = 1'b0;
    speed_down_input       = 1'b0;
    forward_limit_b_switch = 1'b0;
  end

  // Levels launched after the edge, as a real controller output would move
  always @(posedge pclk) begin
    speed_up_input         <= want_up;
    speed_down_input       <= want_down;
    forward_limit_b_switch <= want_b;
  end
endmodule // scrl_pin_ctrl

// *** test/speed_command_ramp_limit_tb.sv ***
// Self-checking bench: APB tasks, limit table, ramp, filter and up/down sequences.
// Assumes scrl_top with a 20-cycle tick; analog inputs held at fixed levels.
`timescale 1ns/1ps
`include "scrl_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h, expected %h", $time, (g), (e)); end end

module speed_command_ramp_limit_tb
  import scrl_pkg::*;
;
  logic               pclk, presetn, psel, penable, pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               pready, pslverr, err;
  logic               up_pin, down_pin, b_pin, want_up, want_down, want_b;
  logic signed [15:0] speed_source, analog_one, analog_two, speed_command, v1;
  int                 failures, n_tests, cycles;
  // Limit table: select, A source, B source, switch, expected clamp
  logic [22:0]        lt [12] = '{
    {2'd0, 2'd0, 2'd0, 1'b0, 16'd2000}, {2'd1, 2'd0, 2'd0, 1'b0, 16'd1500},
    {2'd2, 2'd0, 2'd0, 1'b0, 16'd2000}, {2'd2, 2'd0, 2'd0, 1'b1, 16'd1500},
    {2'd3, 2'd0, 2'd0, 1'b0, 16'd1500}, {2'd0, 2'd1, 2'd0, 1'b0, 16'd1200},
    {2'd0, 2'd2, 2'd0, 1'b0, 16'd800},  {2'd1, 2'd0, 2'd1, 1'b0, 16'd1200},
    {2'd1, 2'd0, 2'd2, 1'b0, 16'd800},  {2'd3, 2'd1, 2'd2, 1'b0, 16'd800},
    {2'd3, 2'd1, 2'd0, 1'b0, 16'd1200}, {2'd0, 2'd3, 2'd0, 1'b0, 16'd2000}};
  logic [7:0]         ro [6] = '{`SCRL_OFS_FILT_TC, `SCRL_OFS_ACC_TIME, `SCRL_OFS_FWD_SEL,
                                 `SCRL_OFS_A_SRC, `SCRL_OFS_A_VAL, `SCRL_OFS_B_SRC};
  logic [31:0]        rv [6] = '{32'h14, 32'h1f4, 32'h0, 32'h0, 32'hbb8, 32'h0};

  scrl_top #(.TICK_CYCLES(20), .RATED_RPM(3000)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_up_input(up_pin), .speed_down_input(down_pin), .forward_limit_b_switch(b_pin),
    .speed_source(speed_source), .analog_input_one(analog_one),
    .analog_input_two(analog_two), .speed_command(speed_command));

  scrl_pin_ctrl PINS (
    .pclk(pclk), .want_up(want_up), .want_down(want_down), .want_b(want_b),
    .speed_up_input(up_pin), .speed_down_input(down_pin), .forward_limit_b_switch(b_pin));

  always #4 pclk = ~pclk;

  // Hang guard: the sequence needs about 4400 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 9000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen, then one idle edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n == 100) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; want_up = 1'b0; want_down = 1'b0; want_b = 1'b0;
    speed_source = 16'sd5000; analog_one = 16'sd1200; analog_two = 16'sd800;
    failures = 0; n_tests = 0; cycles = 0;
    idle(20);
    presetn <= 1'b1;
    // Reset values, then an unmapped place and an over-range filter constant
    for (int i = 0; i < 6; i++) begin
      apb(ro[i], 1'b0, 32'h0);
      `CHK(rd, rv[i])
    end
    apb(8'h40, 1'b0, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    wr(`SCRL_OFS_FILT_TC, 32'hffff);
    apb(`SCRL_OFS_FILT_TC, 1'b0, 32'h0);
    `CHK(rd, 32'h7fff)
    // Instant ramp and pass-through filter so the limit alone shapes the command
    wr(`SCRL_OFS_FILT_TC, 32'h0); wr(`SCRL_OFS_ACC_TIME, 32'h0); wr(`SCRL_OFS_DEC_TIME, 32'h0);
    wr(`SCRL_OFS_A_VAL, 32'd2000); wr(`SCRL_OFS_B_VAL, 32'd1500);
    for (int i = 0; i < 12; i++) begin
      wr(`SCRL_OFS_FWD_SEL, {30'h00000000, lt[i][22:21]});
      wr(`SCRL_OFS_A_SRC, {30'h00000000, lt[i][20:19]});
      wr(`SCRL_OFS_B_SRC, {30'h00000000, lt[i][18:17]});
      want_b <= lt[i][16];
      idle(80);
      `CHK(speed_command, lt[i][15:0])
      apb(`SCRL_OFS_ST_TARGET, 1'b0, 32'h0);
      `CHK(rd, {16'h0000, lt[i][15:0]})
    end
    // Slope: 300 ms gives 1 rpm per 2 cycles up, 150 ms 1 rpm per cycle down
    speed_source <= 16'sd0;
    idle(80);
    wr(`SCRL_OFS_ACC_TIME, 32'd300); wr(`SCRL_OFS_DEC_TIME, 32'd150);
    speed_source <= 16'sd100;
    idle(97);
    apb(`SCRL_OFS_ST_RAMP, 1'b0, 32'h0);
    `CHK(rd >= 44 && rd <= 56, 1'b1)
    idle(150);
    apb(`SCRL_OFS_ST_RAMP, 1'b0, 32'h0);
    `CHK(rd, 32'd100)
    speed_source <= 16'sd0;
    idle(47);
    apb(`SCRL_OFS_ST_RAMP, 1'b0, 32'h0);
    `CHK(rd >= 44 && rd <= 56, 1'b1)
    // Filter lag with tc 9, then a write of tc 0 acts at once
    wr(`SCRL_OFS_ACC_TIME, 32'h0); wr(`SCRL_OFS_DEC_TIME, 32'h0);
    idle(80);
    wr(`SCRL_OFS_FILT_TC, 32'd9);
    speed_source <= 16'sd1000;
    idle(30);
    `CHK(speed_command > 0 && speed_command < 1000, 1'b1)
    idle(2000);
    `CHK(speed_command >= 998 && speed_command <= 1000, 1'b1)
    speed_source <= 16'sd0;
    idle(30);
    wr(`SCRL_OFS_FILT_TC, 32'd0);
    idle(25);
    `CHK(speed_command, 16'sd0)
    // Up/down mode with 5 rpm per tick: raise, hold, both, lower
    wr(`SCRL_OFS_STEP, 32'd5); wr(`SCRL_OFS_CTRL, 32'h1);
    want_up <= 1'b1;
    idle(200);
    want_up <= 1'b0;
    idle(60);
    v1 = speed_command;
    `CHK(v1 >= 40 && v1 <= 60, 1'b1)
    idle(100);
    `CHK(speed_command, v1)
    want_up <= 1'b1; want_down <= 1'b1;
    idle(100);
    want_up <= 1'b0; want_down <= 1'b0;
    idle(60);
    `CHK(speed_command, v1)
    want_down <= 1'b1;
    idle(100);
    want_down <= 1'b0;
    idle(60);
    `CHK(v1 - speed_command >= 20 && v1 - speed_command <= 30, 1'b1)
    test_done();
  end
endmodule // speed_command_ramp_limit_tb
